// ---- btsu_pkg.sv ----
// btsu_pkg: constants for the bit-test-and-skip unit
// assumes 12-bit instruction words and a 32-entry, 8-bit file register space
package btsu_pkg;
   localparam int unsigned btsu_iw_w = 12;
   localparam int unsigned btsu_fa_w = 5;
   localparam int unsigned btsu_bi_w = 3;
   localparam int unsigned btsu_dw = 8;
   localparam int unsigned btsu_op_msb = 11;
   localparam int unsigned btsu_op_lsb = 8;
   localparam int unsigned btsu_bi_msb = 7;
   localparam int unsigned btsu_bi_lsb = 5;
   localparam int unsigned btsu_fa_msb = 4;
   localparam int unsigned btsu_fa_lsb = 0;
   localparam logic [3:0] btsu_op_skip_clear = 4'h6;
   localparam logic [3:0] btsu_op_skip_set = 4'h7;
   localparam logic [btsu_iw_w-1:0] btsu_nop_word = 12'h000;
   localparam logic [btsu_iw_w-1:0] btsu_rst_word = 12'h000;
   localparam logic [btsu_fa_w-1:0] btsu_rst_addr = 5'h00;
   typedef enum logic [1:0] {
      btsu_st_run,
      btsu_st_test,
      btsu_st_squash
   } btsu_state_t;
endpackage : btsu_pkg

// ---- btsu_bit_sel.sv ----
// btsu_bit_sel: registered bit pick from an 8-bit file value
// assumes file data is valid in the cycle sel_en is high
`timescale 1ns/10ps
`default_nettype none
module btsu_bit_sel
   import btsu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic sel_en,
   input wire logic [btsu_dw-1:0] data,
   input wire logic [btsu_bi_w-1:0] index,
   output logic bit_ff
);
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         bit_ff <= 1'b0;
      end else if (sel_en) begin
         bit_ff <= data[index];
      end
   end
endmodule // btsu_bit_sel
`default_nettype wire

// ---- btsu_core.sv ----
// btsu_core: decode and execute of the two bit-test-and-skip instructions
// assumes fetch supplies one word per cycle with a valid strobe, and the
// register file answers a read address with data within the same cycle
`timescale 1ns/10ps
`default_nettype none
module btsu_core
   import btsu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [btsu_iw_w-1:0] instr_word,
   input wire logic instr_valid,
   input wire logic [btsu_dw-1:0] file_rdata,
   output logic [btsu_fa_w-1:0] file_raddr_ff,
   output logic [btsu_iw_w-1:0] exec_word_ff,
   output logic exec_valid_ff,
   output logic squash_ff,
   output logic skip_taken_ff,
   output logic test_busy_ff
);
   btsu_state_t state_ff;
   btsu_state_t nxt_state;
   logic pol_ff;
   logic [btsu_bi_w-1:0] index_ff;
   logic sel_bit_ff;
   logic is_test;
   logic skip_now;

   function automatic logic is_bit_test(input logic [btsu_iw_w-1:0] w);
      is_bit_test = (w[btsu_op_msb:btsu_op_lsb] == btsu_op_skip_clear) ||
         (w[btsu_op_msb:btsu_op_lsb] == btsu_op_skip_set);
   endfunction

   // skip condition: selected bit equals the form's polarity
   function automatic logic bit_hit(input logic [btsu_dw-1:0] d,
      input logic [btsu_bi_w-1:0] idx, input logic pol);
      bit_hit = (d[idx] == pol);
   endfunction

   // decided on live file data so the word fetched during the test is
   // the one squashed; a squashed word is never decoded
   assign skip_now = (state_ff == btsu_st_test) &&
      bit_hit(file_rdata, index_ff, pol_ff);
   assign is_test = instr_valid && is_bit_test(instr_word) && !skip_now;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         btsu_st_run: begin
            if (is_test) begin
               nxt_state = btsu_st_test;
            end
         end
         btsu_st_test: begin
            if (skip_now) begin
               nxt_state = btsu_st_squash;
            end else if (is_test) begin
               nxt_state = btsu_st_test;
            end else begin
               nxt_state = btsu_st_run;
            end
         end
         btsu_st_squash: begin
            // the no-op slot is already out; the next word decodes normally
            if (is_test) begin
               nxt_state = btsu_st_test;
            end else begin
               nxt_state = btsu_st_run;
            end
         end
         default: begin
            nxt_state = btsu_st_run;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_ff <= btsu_st_run;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // operand capture; file read issued while the next word is fetched
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         file_raddr_ff <= btsu_rst_addr;
         index_ff <= '0;
         pol_ff <= 1'b0;
      end else if (is_test) begin
         file_raddr_ff <= instr_word[btsu_fa_msb:btsu_fa_lsb];
         index_ff <= instr_word[btsu_bi_msb:btsu_bi_lsb];
         pol_ff <= instr_word[btsu_op_lsb];
      end
   end

   // tested bit kept one cycle; the skip checks compare it with the squash
   btsu_bit_sel u_bit_sel (
      .ref_clk(ref_clk),
      .reset(reset),
      .sel_en(state_ff == btsu_st_test),
      .data(file_rdata),
      .index(index_ff),
      .bit_ff(sel_bit_ff)
   );

   // execute slot: the prefetched word passes unless a skip squashes it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         exec_word_ff <= btsu_rst_word;
         exec_valid_ff <= 1'b0;
      end else if (skip_now) begin
         exec_word_ff <= btsu_nop_word;
         exec_valid_ff <= 1'b1;
      end else begin
         exec_word_ff <= instr_word;
         exec_valid_ff <= instr_valid;
      end
   end

   // squash marker and skip flag: one-cycle pulses with the no-op slot
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         squash_ff <= 1'b0;
         skip_taken_ff <= 1'b0;
      end else begin
         squash_ff <= skip_now;
         skip_taken_ff <= skip_now;
      end
   end

   // decode strobe, squashed words excluded
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         test_busy_ff <= 1'b0;
      end else begin
         test_busy_ff <= is_test;
      end
   end

   // skip outcome checked against the separately registered tested bit, and a skip only right after a test cycle
   chk_clear_form_skip: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == btsu_st_test && !pol_ff) |=> (squash_ff == !sel_bit_ff))
      else $error("clear-form test skipped on the wrong bit value");
   chk_set_form_skip: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == btsu_st_test && pol_ff) |=> (squash_ff == sel_bit_ff))
      else $error("set-form test skipped on the wrong bit value");
   chk_no_false_skip: assert property (@(posedge ref_clk) disable iff (reset)
      squash_ff |-> ($past(state_ff) == btsu_st_test))
      else $error("skip taken without a bit test before it");

   chk_squash_is_nop: assert property (@(posedge ref_clk) disable iff (reset)
      squash_ff |-> (exec_word_ff == btsu_nop_word) && exec_valid_ff)
      else $error("squashed slot did not carry a no-op");
   chk_squashed_not_decoded: assert property (@(posedge ref_clk) disable iff (reset)
      (skip_now && instr_valid && instr_word[11:9] == 3'h3) |=> !test_busy_ff)
      else $error("squashed bit-test word was decoded");
   chk_idle_no_slot: assert property (@(posedge ref_clk) disable iff (reset)
      (!instr_valid && !skip_now) |=> !exec_valid_ff)
      else $error("execute slot raised without a fetched word");
   chk_prefetch_passes: assert property (@(posedge ref_clk) disable iff (reset)
      (!skip_now) |=> (exec_word_ff == $past(instr_word)))
      else $error("prefetched word not passed to execute");
   chk_fetch_order: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == btsu_st_test && !skip_now && instr_valid) |=> exec_valid_ff && !squash_ff)
      else $error("word fetched during an unskipped test did not run");

   chk_state_after_skip: assert property (@(posedge ref_clk) disable iff (reset)
      skip_now |=> (state_ff == btsu_st_squash))
      else $error("skip did not enter the no-op cycle");
   chk_skip_two_cycles: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == btsu_st_squash) |-> squash_ff ##1 !squash_ff)
      else $error("skip did not end after its no-op cycle");
   chk_skip_flag_pair: assert property (@(posedge ref_clk) disable iff (reset)
      skip_taken_ff == squash_ff)
      else $error("skip flag and squash marker disagree");
   chk_one_word_each: assert property (@(posedge ref_clk) disable iff (reset)
      test_busy_ff |-> exec_valid_ff && !squash_ff)
      else $error("bit-test word did not take exactly one slot");
   chk_test_one_cycle: assert property (@(posedge ref_clk) disable iff (reset)
      (is_test && state_ff == btsu_st_run) |=> (state_ff == btsu_st_test) ##1
         (state_ff != btsu_st_test || $past(is_test)))
      else $error("test did not resolve in one cycle");

   chk_decode_fields: assert property (@(posedge ref_clk) disable iff (reset)
      is_test |=> (file_raddr_ff == $past(instr_word[4:0])) &&
         (index_ff == $past(instr_word[7:5])))
      else $error("operand fields decoded wrongly");
   chk_opcode_decoded: assert property (@(posedge ref_clk) disable iff (reset)
      (instr_valid && instr_word[11:9] == 3'h3 && !skip_now) |=> test_busy_ff)
      else $error("bit-test opcode not decoded");
   chk_test_enters: assert property (@(posedge ref_clk) disable iff (reset)
      is_test |=> (state_ff == btsu_st_test))
      else $error("decoded test did not enter the test state");
   chk_other_op_ignored: assert property (@(posedge ref_clk) disable iff (reset)
      (!instr_valid || instr_word[11:9] != 3'h3) |=> !test_busy_ff)
      else $error("non-test word was decoded as a test");
   chk_operands_hold: assert property (@(posedge ref_clk) disable iff (reset)
      !is_test |=> $stable(file_raddr_ff) && $stable(index_ff) && $stable(pol_ff))
      else $error("operands changed without a decoded test");
   chk_polarity_from_op: assert property (@(posedge ref_clk) disable iff (reset)
      is_test |=> (pol_ff == $past(instr_word[8])))
      else $error("polarity not taken from the opcode");

   // main scenarios
   cov_skip_clear: cover property (@(posedge ref_clk) disable iff (reset)
      skip_now && !pol_ff);
   cov_skip_set: cover property (@(posedge ref_clk) disable iff (reset)
      skip_now && pol_ff);
   cov_no_skip: cover property (@(posedge ref_clk) disable iff (reset)
      state_ff == btsu_st_test && !skip_now);
   cov_back_to_back: cover property (@(posedge ref_clk) disable iff (reset)
      state_ff == btsu_st_test && is_test);
   cov_test_in_squash: cover property (@(posedge ref_clk) disable iff (reset)
      skip_now && instr_valid && is_bit_test(instr_word));
endmodule // btsu_core
`default_nettype wire

// ---- tb.sv ----
// tb: self-checking bench for btsu_core, order-based scoreboard on the execute slots
// assumes btsu_pkg is compiled first; the file registers are modelled in the bench
`timescale 1ns/10ps
`default_nettype none
`define CMP(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin fails++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb import btsu_pkg::*; ;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic instr_valid = 1'b0;
   logic [btsu_iw_w-1:0] instr_word = 12'h000;
   logic [btsu_dw-1:0] file_rdata = 8'h00;
   wire logic [btsu_fa_w-1:0] file_raddr_ff;
   wire logic [btsu_iw_w-1:0] exec_word_ff;
   wire logic exec_valid_ff, squash_ff, skip_taken_ff, test_busy_ff;
   logic [btsu_dw-1:0] regs [32];
   logic [btsu_iw_w+1:0] expq [$];
   logic [btsu_iw_w+1:0] e;
   logic skip_pend = 1'b0;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   btsu_core btsu_core_i (.ref_clk(ref_clk), .reset(reset), .instr_word(instr_word),
      .instr_valid(instr_valid), .file_rdata(file_rdata), .file_raddr_ff(file_raddr_ff),
      .exec_word_ff(exec_word_ff), .exec_valid_ff(exec_valid_ff), .squash_ff(squash_ff),
      .skip_taken_ff(skip_taken_ff), .test_busy_ff(test_busy_ff));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // data follows the address one half cycle later, inside the allowed window
   always @(negedge ref_clk) begin
      file_rdata <= regs[file_raddr_ff];
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // one word per cycle; the model predicts which slot becomes the no-op
   task automatic send(input logic [btsu_iw_w-1:0] w);
      logic [3:0] op;
      op = w[btsu_op_msb:btsu_op_lsb];
      instr_word = w;
      instr_valid = 1'b1;
      if (skip_pend) begin
         expq.push_back({1'b1, 1'b0, btsu_nop_word});
         skip_pend = 1'b0;
      end else begin
         expq.push_back({1'b0, op == btsu_op_skip_clear || op == btsu_op_skip_set, w});
         if (op == btsu_op_skip_clear || op == btsu_op_skip_set)
            skip_pend = regs[w[4:0]][w[7:5]] == op[0];
      end
      @(negedge ref_clk);
   endtask
   task automatic burst(input int n);
      logic [btsu_iw_w-1:0] w;
      repeat (n) begin
         w = 12'($urandom);
         if ($urandom % 2) w[11:9] = 3'b011;
         else if (w[11:9] == 3'b011) w[11] = 1'b1;
         send(w);
      end
      send(12'h8a5);
      instr_valid = 1'b0;
      repeat (6) @(negedge ref_clk);
   endtask
   // execute slots compared in order; an extra slot shows up at once, a missing one only at a later slot or in the final slots_left count
   always @(negedge ref_clk) begin
      if (!reset && exec_valid_ff === 1'b1) begin
         if (expq.size() == 0) `CMP("extra_slot", 1'b0, 1'b1)
         else begin
            e = expq.pop_front();
            `CMP("exec_word", e[11:0], exec_word_ff)
            `CMP("squash", e[13], squash_ff)
            `CMP("skip_taken", e[13], skip_taken_ff)
            `CMP("test_busy", e[12], test_busy_ff)
            if (e[12]) `CMP("file_addr", e[4:0], file_raddr_ff)
         end
      end
   end
   initial begin
      void'($urandom(32'hc11eab12));
      foreach (regs[i]) regs[i] = 8'($urandom);
      regs[31] = 8'h80;
      regs[0] = 8'h01;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) reset = 1'b0;
      // both forms, both outcomes, edge bit indices on the top address
      for (int p = 0; p < 2; p++) begin
         for (int b = 0; b < 8; b += 7) begin
            send({3'b011, p[0], b[2:0], 5'h1f});
            send(12'h8a5);
         end
      end
      // a test word in the squash slot must not be decoded
      send({3'b011, 1'b1, 3'h7, 5'h1f});
      send({3'b011, 1'b1, 3'h0, 5'h00});
      send({3'b011, 1'b0, 3'h0, 5'h00});
      send({3'b011, 1'b0, 3'h1, 5'h00});
      burst(300);
      reset = 1'b1;
      @(negedge ref_clk);
      `CMP("reset_valid", 1'b0, exec_valid_ff)
      `CMP("reset_squash", 1'b0, squash_ff)
      reset = 1'b0;
      foreach (regs[i]) regs[i] = 8'($urandom);
      burst(60);
      `CMP("slots_left", 0, expq.size())
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
